// ---- dv/erma_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module erma_core_chk
  import erma_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Events
  input wire logic exc_take,
  input wire logic eret_exec,
  input wire logic div_exec,
  input wire logic div_signed,
  input wire logic [31:0] div_num,
  input wire logic [31:0] div_den,
  input wire logic div_error,
  input wire logic fetch_redirect,
  input wire logic proc_ie,
  // Load/store
  input wire logic ls_req,
  input wire logic ls_io,
  input wire logic [1:0] ls_size,
  input wire logic [31:0] ls_vaddr,
  input wire logic [31:0] dbus_addr,
  input wire logic [3:0] dbus_be,
  input wire logic dbus_rd,
  input wire logic dbus_wr,
  input wire logic dbus_bypass,
  input wire logic dbus_ack,
  input wire logic ls_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_div_zero: assert property (div_exec && div_den == DIV_ZERO
    |=> div_error) else $error("no divide error on zero");
  chk_div_ovf: assert property (div_exec && div_signed &&
    div_num == DIV_MIN_NEG && div_den == DIV_MINUS1 |=> div_error)
    else $error("no divide error on overflow");
  chk_div_quiet: assert property (!div_exec |=> !div_error)
    else $error("spurious divide error");
  chk_eret_redir: assert property (eret_exec && !exc_take
    |=> fetch_redirect ##1 !fetch_redirect) else $error("no redirect");
  chk_ie_clear: assert property (exc_take ##1 !eret_exec
    |=> !proc_ie) else $error("interrupts still enabled");
  chk_io_bypass: assert property (ls_req && ls_io
    |=> dbus_bypass) else $error("io access cached");
  chk_page_off: assert property (ls_req
    |=> dbus_addr[11:0] == $past(ls_vaddr[11:0])) else $error("offset");
  chk_byte_lane: assert property (ls_req && ls_size == SZ_BYTE &&
    ls_vaddr[1:0] == 2'h3 |=> dbus_be == 4'h8) else $error("lane");
  chk_rd_hold: assert property (dbus_rd && !dbus_ack |=> dbus_rd)
    else $error("read dropped early");
  chk_done_ack: assert property ((dbus_rd || dbus_wr) && dbus_ack
    |=> ls_done && !dbus_rd && !dbus_wr) else $error("no done");
  cov_eret: cover property (fetch_redirect);
  cov_div: cover property (div_error);
  cov_bypass: cover property (ls_done && dbus_bypass);
endmodule // erma_core_chk
bind erma_core erma_core_chk i_erma_core_chk (.clk, .rst_b, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .exc_take, .eret_exec, .div_exec, .div_signed,
  .div_num, .div_den, .div_error, .fetch_redirect, .proc_ie, .ls_req,
  .ls_io, .ls_size, .ls_vaddr, .dbus_addr, .dbus_be, .dbus_rd, .dbus_wr,
  .dbus_bypass, .dbus_ack, .ls_done);
`default_nettype wire

// ---- dv/erma_dbus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Data bus memory, answers after lat wait cycles
// ----
module erma_dbus_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Requests from the core
  input wire logic [31:0] dbus_addr,
  input wire logic [3:0] dbus_be,
  input wire logic [31:0] dbus_wdata,
  input wire logic dbus_rd,
  input wire logic dbus_wr,
  // Answer
  input wire logic [3:0] lat,
  output logic dbus_ack,
  output logic [31:0] dbus_rdata
);
  logic [31:0] mem_q [16]; // Word store, aliases above 64 bytes
  logic [31:0] last_q; // Data of the last answer
  logic [3:0] wait_q; // Cycles waited
  // Stale data is inverted so a late sample never matches
  assign dbus_rdata = dbus_ack ? last_q : ~last_q;
  // Answer one request, lane i is byte address i
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dbus_ack <= 1'b0;
      wait_q <= 4'h0;
      last_q <= 32'h0;
    end else if (dbus_ack) begin
      dbus_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (dbus_rd || dbus_wr) begin
      if (wait_q == lat) begin
        dbus_ack <= 1'b1;
        last_q <= mem_q[dbus_addr[5:2]];
        for (int i = 0; i < 4; i++) begin
          if (dbus_wr && dbus_be[i]) begin
            mem_q[dbus_addr[5:2]][8*i +: 8] <= dbus_wdata[8*i +: 8];
          end
        end
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule // erma_dbus_model
`default_nettype wire

// ---- dv/test_erma_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_erma_core;
  import erma_pkg::*;
  // ----
  // Stimulus and results
  // ----
  logic clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF, lat = 0, dbus_be, gbe;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q, ga, gq, dbus_rdata;
  logic wb_ack_o, exc_take = 0, eret_exec = 0, div_exec = 0, gby;
  logic [7:0] exc_req = 0;
  logic [31:0] exc_pc = 0, exc_data_addr = 0, div_num = 0, div_den = 0;
  logic div_signed = 0, ls_req = 0, ls_we = 0, ls_io = 0, ls_signed = 0;
  logic [1:0] ls_size = 0;
  logic [31:0] ls_vaddr = 0, ls_wdata = 0, ls_rdata, dbus_addr, dbus_wdata;
  logic [19:0] ls_pfn = 0, dbus_tag;
  logic ls_tlb_cache = 1, cache_op = 0, ls_done, dbus_rd, dbus_wr;
  logic dbus_bypass, cache_op_fire, dbus_ack, fetch_redirect;
  logic div_error, proc_ie;
  logic [11:0] dbus_line_idx;
  logic [31:0] fetch_target;
  int bad_count = 0, tests_run = 0, cycles = 0;
  always #50 clk = ~clk;
  erma_core i_erma_core (.*);
  erma_dbus_model i_erma_dbus_model (.*);
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic take(input logic [7:0] r, input logic [31:0] pc, da);
    @(posedge clk);
    exc_take <= 1'b1;
    exc_req <= r;
    exc_pc <= pc;
    exc_data_addr <= da;
    @(posedge clk) exc_take <= 1'b0;
  endtask
  task automatic dv(input logic s, input logic [31:0] n, d, input logic e);
    @(posedge clk);
    div_exec <= 1'b1;
    div_signed <= s;
    div_num <= n;
    div_den <= d;
    @(posedge clk) div_exec <= 1'b0;
    @(negedge clk);
    chk("div_error", {31'h0, e}, {31'h0, div_error});
  endtask
  task automatic cop(input logic e);
    @(posedge clk) cache_op <= 1'b1;
    @(posedge clk) cache_op <= 1'b0;
    @(negedge clk);
    chk("cache_fire", {31'h0, e}, {31'h0, cache_op_fire});
  endtask
  // One access; bus fields captured in the first bus cycle
  task automatic ls(input logic w, io, input logic [1:0] sz,
                    input logic sg, input logic [31:0] va, wd);
    @(posedge clk);
    ls_req <= 1'b1;
    ls_we <= w;
    ls_io <= io;
    ls_size <= sz;
    ls_signed <= sg;
    ls_vaddr <= va;
    ls_wdata <= wd;
    @(posedge clk) ls_req <= 1'b0;
    @(negedge clk);
    ga = dbus_addr;
    gbe = dbus_be;
    gby = dbus_bypass;
    repeat (40) begin
      if (ls_done === 1'b1) break;
      @(negedge clk);
    end
    chk("ls_done", 32'h1, {31'h0, ls_done});
    gq = ls_rdata;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    rdc(REG_CONFIG, {27'h0, CONFIG_RST}, "config");
    rdc(8'h3C, 32'h0, "unmapped");
    wb(1'b1, REG_STATUS, 32'h1);
    rdc(REG_STATUS, 32'h1, "status");
  endtask
  // Handler saves state, nests a trap, restores it, then returns
  task automatic t_exc();
    logic [31:0] sv_st, sv_ra;
    take(8'h41, 32'h100, 32'h345);
    rdc(REG_CAUSE, {27'h0, CAUSE_IRQ}, "cause_prio");
    rdc(REG_RETADDR, 32'h104, "ret_addr");
    sv_ra = q - RET_STEP;
    rdc(REG_ESTATUS, 32'h1, "estatus");
    sv_st = q;
    chk("saved_ie", 32'h1, {31'h0, sv_st[ST_PIE]});
    chk("proc_ie", 32'h0, {31'h0, proc_ie});
    take(8'h20, 32'h180, 32'h0);
    rdc(REG_RETADDR, 32'h184, "ret_nest");
    rdc(REG_ESTATUS, 32'h0, "estatus_nest");
    wb(1'b1, REG_ESTATUS, sv_st);
    wb(1'b1, REG_RETADDR, sv_ra);
    @(posedge clk) eret_exec <= 1'b1;
    @(posedge clk) eret_exec <= 1'b0;
    @(negedge clk);
    chk("redirect", 32'h1, {31'h0, fetch_redirect});
    chk("target", 32'h100, fetch_target);
    rdc(REG_STATUS, 32'h1, "status_back");
    take(8'h40, 32'h200, 32'h345);
    rdc(REG_CAUSE, {27'h0, CAUSE_MISDATA}, "cause_mis");
    rdc(REG_FAULT, 32'h345, "fault");
  endtask
  task automatic t_div();
    dv(1'b0, 32'h7, DIV_ZERO, 1'b1);
    dv(1'b1, DIV_MIN_NEG, DIV_MINUS1, 1'b1);
    dv(1'b0, DIV_MIN_NEG, DIV_MINUS1, 1'b0);
    dv(1'b1, 32'h7, 32'h2, 1'b0);
  endtask
  task automatic t_ls();
    ls(1'b1, 1'b0, SZ_WORD, 1'b0, 32'h10, 32'h11223344);
    chk("be_word", 32'hF, {28'h0, gbe});
    chk("cached", 32'h0, {31'h0, gby});
    lat = 4'h3;
    ls(1'b0, 1'b0, SZ_BYTE, 1'b1, 32'h11, 32'h0);
    chk("ld_byte", 32'h33, gq);
    ls(1'b0, 1'b0, SZ_HALF, 1'b0, 32'h12, 32'h0);
    chk("ld_half", 32'h1122, gq);
    ls(1'b1, 1'b0, SZ_BYTE, 1'b0, 32'h13, 32'hF0);
    ls(1'b0, 1'b0, SZ_BYTE, 1'b1, 32'h13, 32'h0);
    chk("ld_sext", 32'hFFFFFFF0, gq);
    ls(1'b0, 1'b0, SZ_WORD, 1'b0, 32'h80000010, 32'h0);
    chk("b31_addr", 32'h10, ga);
    chk("b31_byp", 32'h1, {31'h0, gby});
    chk("ld_word", 32'hF0223344, gq);
    ls(1'b0, 1'b1, SZ_WORD, 1'b0, 32'h10, 32'h0);
    chk("io_byp", 32'h1, {31'h0, gby});
  endtask
  task automatic t_mmu();
    cop(1'b1);
    wb(1'b1, REG_CONFIG, 32'h18);
    rdc(REG_CAUSE, 32'h0, "cause_off");
    rdc(REG_FAULT, 32'h0, "fault_off");
    wb(1'b1, REG_CONFIG, 32'h2);
    cop(1'b0);
    take(8'h80, 32'h300, 32'h0);
    rdc(REG_CAUSE, {27'h0, CAUSE_DIVERR}, "cause_mmu");
    take(8'h84, 32'h400, 32'h0);
    rdc(REG_FAULT, 32'h400, "fault_pc");
    @(posedge clk) ls_pfn <= 20'hABCDE;
    ls(1'b0, 1'b0, SZ_WORD, 1'b0, 32'h80000120, 32'h0);
    chk("mmu_addr", 32'hABCDE120, ga);
    chk("mmu_byp", 32'h0, {31'h0, gby});
    chk("mmu_tag", 32'hABCDE, {12'h0, dbus_tag});
    chk("line_idx", 32'h12, {20'h0, dbus_line_idx});
    // Alias of the same frame keeps the same colour bits
    ls(1'b0, 1'b0, SZ_WORD, 1'b0, 32'h00000120, 32'h0);
    chk("alias_idx", 32'h12, {20'h0, dbus_line_idx});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_exc();
    t_div();
    t_ls();
    t_mmu();
    report_and_stop();
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
endmodule // test_erma_core
`default_nettype wire

// ---- hdl/erma_core.sv ----
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module erma_core
  import erma_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Exception events from the pipeline
  input wire logic exc_take,
  input wire logic [NUM_EXC-1:0] exc_req,
  input wire logic [ADDR_W-1:0] exc_pc,
  input wire logic [ADDR_W-1:0] exc_data_addr,
  input wire logic eret_exec,
  // Divide check
  input wire logic div_exec,
  input wire logic div_signed,
  input wire logic [31:0] div_num,
  input wire logic [31:0] div_den,
  // Load/store request
  input wire logic ls_req,
  input wire logic ls_we,
  input wire logic ls_io,
  input wire logic [1:0] ls_size,
  input wire logic ls_signed,
  input wire logic [ADDR_W-1:0] ls_vaddr,
  input wire logic [PFN_W-1:0] ls_pfn,
  input wire logic ls_tlb_cache,
  input wire logic [31:0] ls_wdata,
  input wire logic cache_op,
  // Load/store results
  output logic ls_done,
  output logic [31:0] ls_rdata,
  // Data bus master
  output logic [ADDR_W-1:0] dbus_addr,
  output logic [3:0] dbus_be,
  output logic [31:0] dbus_wdata,
  output logic dbus_rd,
  output logic dbus_wr,
  output logic dbus_bypass,
  output logic [LINE_HI-LINE_LO:0] dbus_line_idx,
  output logic [PFN_W-1:0] dbus_tag,
  output logic cache_op_fire,
  input wire logic dbus_ack,
  input wire logic [31:0] dbus_rdata,
  // Fetch redirect, divide error and interrupt enable
  output logic fetch_redirect,
  output logic [ADDR_W-1:0] fetch_target,
  output logic div_error,
  output logic proc_ie
);
  import erma_pkg::*;

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  logic [STAT_W-1:0] status_q; // Live status
  logic [STAT_W-1:0] estatus_q; // Saved status
  logic [ADDR_W-1:0] exception_return_address_q;
  logic [CAUSE_W-1:0] cause_q; // Reported cause code
  logic [ADDR_W-1:0] faulting_address_value_q;
  logic [4:0] config_q; // Build options, software visible
  logic extra_on; // Extra info effectively enabled
  logic wb_hit;
  logic [31:0] rd_d;

  // Extra info forced by MMU or MPU
  assign extra_on = config_q[CF_EXTRA] | config_q[CF_MMU]
                  | config_q[CF_MPU];

  // -------------------------------------------------------------
  // Priority encode of exceptions
  // -------------------------------------------------------------
  logic [CAUSE_W-1:0] cause_d;
  logic fault_is_data;
  logic fault_is_inst;
  always_comb begin
    // Lowest index is highest priority
    cause_d = CAUSE_NONE;
    fault_is_data = 1'b0;
    fault_is_inst = 1'b0;
    if (exc_req[EV_IRQ]) begin
      cause_d = CAUSE_IRQ;
    end else if (exc_req[EV_MEMFAULT]) begin
      cause_d = CAUSE_MEMFAULT;
      fault_is_data = 1'b1;
    end else if (exc_req[EV_MISDEST]) begin
      cause_d = CAUSE_MISDEST;
      fault_is_inst = 1'b1;
    end else if (exc_req[EV_UNIMP]) begin
      cause_d = CAUSE_UNIMP;
    end else if (exc_req[EV_ILLEGAL]) begin
      cause_d = CAUSE_ILLEGAL;
    end else if (exc_req[EV_TRAP]) begin
      cause_d = CAUSE_TRAP;
    end else if (exc_req[EV_MISDATA]) begin
      cause_d = CAUSE_MISDATA;
      fault_is_data = 1'b1;
    end else if (exc_req[EV_DIVERR]) begin
      cause_d = CAUSE_DIVERR;
    end
  end

  // -------------------------------------------------------------
  // Status and saved status
  // -------------------------------------------------------------
  // Entry preserves state unless the MMU is on and already handling (EH)
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= STATUS_RST;
      estatus_q <= STATUS_RST;
    end else if (exc_take) begin
      if (!(config_q[CF_MMU] && status_q[ST_EH])) begin
        estatus_q <= status_q;
      end
      status_q[ST_PIE] <= 1'b0;
      if (config_q[CF_MMU]) begin
        status_q[ST_U] <= 1'b0;
        status_q[ST_EH] <= 1'b1;
      end
    end else if (eret_exec) begin
      status_q <= estatus_q;
    end else if (wb_hit && wb_we_i && wb_adr_i == REG_STATUS) begin
      status_q <= wb_dat_i[STAT_W-1:0];
    end else if (wb_hit && wb_we_i && wb_adr_i == REG_ESTATUS) begin
      estatus_q <= wb_dat_i[STAT_W-1:0];
    end
  end

  // -------------------------------------------------------------
  // Return address, cause and faulting address
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exception_return_address_q <= '0;
    end else if (exc_take) begin
      if (!(config_q[CF_MMU] && status_q[ST_EH])) begin
        // Handlers for interrupts subtract the step themselves
        exception_return_address_q <= exc_pc + RET_STEP;
      end
    end else if (wb_hit && wb_we_i && wb_adr_i == REG_RETADDR) begin
      exception_return_address_q <= wb_dat_i;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_q <= CAUSE_NONE;
      faulting_address_value_q <= '0;
    end else if (exc_take && extra_on) begin
      cause_q <= cause_d;
      if (fault_is_data) begin
        faulting_address_value_q <= exc_data_addr;
      end else if (fault_is_inst) begin
        faulting_address_value_q <= exc_pc;
      end
    end
  end

  // Fetch redirect on return
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_redirect <= 1'b0;
      fetch_target <= '0;
    end else begin
      fetch_redirect <= eret_exec && !exc_take;
      if (eret_exec) begin
        fetch_target <= exception_return_address_q;
      end
    end
  end

  // Interrupt enable seen by the interrupt logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) proc_ie <= 1'b0;
    else proc_ie <= status_q[ST_PIE];
  end

  // -------------------------------------------------------------
  // Divide error detection
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_error <= 1'b0;
    end else begin
      div_error <= div_exec && ((div_den == DIV_ZERO) ||
        (div_signed && div_num == DIV_MIN_NEG &&
         div_den == DIV_MINUS1));
    end
  end

  // -------------------------------------------------------------
  // Load/store path
  // -------------------------------------------------------------
  erma_state_e st_q;
  logic [1:0] lane_q; // Low address bits of request
  logic [1:0] size_q;
  logic sign_q;
  logic [3:0] be_d;
  logic [31:0] wd_d;
  logic [31:0] shifted;
  logic [31:0] ext_d;

  // Lane enables and placement, little endian
  always_comb begin
    be_d = 4'h0;
    wd_d = ls_wdata;
    case (ls_size)
      SZ_BYTE: begin
        be_d = 4'h1 << ls_vaddr[1:0];
        wd_d = {4{ls_wdata[7:0]}};
      end
      SZ_HALF: begin
        be_d = ls_vaddr[1] ? 4'hC : 4'h3;
        wd_d = {2{ls_wdata[15:0]}};
      end
      default: begin
        be_d = 4'hF;
      end
    endcase
  end

  // Read data extraction and extension
  always_comb begin
    shifted = dbus_rdata >> {lane_q, 3'b000};
    case (size_q)
      SZ_BYTE: ext_d = {{24{sign_q & shifted[7]}}, shifted[7:0]};
      SZ_HALF: ext_d = {{16{sign_q & shifted[15]}}, shifted[15:0]};
      default: ext_d = shifted;
    endcase
  end

  // Bus transaction; unmapped addresses return whatever the bus gives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ERMA_IDLE;
      dbus_addr <= '0;
      dbus_be <= 4'h0;
      dbus_wdata <= '0;
      dbus_rd <= 1'b0;
      dbus_wr <= 1'b0;
      dbus_bypass <= 1'b0;
      dbus_line_idx <= '0;
      dbus_tag <= '0;
      ls_done <= 1'b0;
      ls_rdata <= '0;
      lane_q <= 2'h0;
      size_q <= SZ_WORD;
      sign_q <= 1'b0;
    end else begin
      ls_done <= 1'b0;
      case (st_q)
        ERMA_IDLE: begin
          if (ls_req) begin
            st_q <= ERMA_BUSY;
            if (config_q[CF_MMU]) begin
              // Physical frame plus untranslated offset
              dbus_addr <= {ls_pfn, ls_vaddr[PAGE_BITS-1:0]};
              dbus_bypass <= ls_io || !ls_tlb_cache;
            end else begin
              // Top bit masked off the bus, 31-bit space
              dbus_addr <= {1'b0, ls_vaddr[ADDR_W-2:0]};
              dbus_bypass <= ls_io ||
                (config_q[CF_B31] && ls_vaddr[BYPASS_BIT]);
            end
            dbus_line_idx <= ls_vaddr[LINE_HI:LINE_LO];
            dbus_tag <= config_q[CF_MMU] ? ls_pfn
                        : ls_vaddr[ADDR_W-1:PAGE_BITS];
            dbus_be <= be_d;
            dbus_wdata <= wd_d;
            dbus_rd <= !ls_we;
            dbus_wr <= ls_we;
            lane_q <= ls_vaddr[1:0];
            size_q <= ls_size;
            sign_q <= ls_signed;
          end
        end
        ERMA_BUSY: begin
          if (dbus_ack) begin
            st_q <= ERMA_IDLE;
            dbus_rd <= 1'b0;
            dbus_wr <= 1'b0;
            ls_done <= 1'b1;
            if (dbus_rd) ls_rdata <= ext_d;
          end
        end
        default: st_q <= ERMA_IDLE;
      endcase
    end
  end

  // Cache operations do nothing without a cache
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cache_op_fire <= 1'b0;
    else cache_op_fire <= cache_op && config_q[CF_CACHE];
  end

  // -------------------------------------------------------------
  // Wishbone slave, one wait state, unmapped reads zero
  // -------------------------------------------------------------
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    case (wb_adr_i)
      REG_STATUS: rd_d = {28'h0, status_q};
      REG_ESTATUS: rd_d = {28'h0, estatus_q};
      REG_RETADDR: rd_d = exception_return_address_q;
      REG_CAUSE: rd_d = {27'h0, extra_on ? cause_q : CAUSE_NONE};
      REG_FAULT: rd_d = extra_on ? faulting_address_value_q : 32'h0;
      REG_CONFIG: rd_d = {27'h0, config_q};
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit) wb_dat_o <= rd_d;
    end
  end

  // Build options, writable so one netlist covers all variants
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) config_q <= CONFIG_RST;
    else if (wb_hit && wb_we_i && wb_adr_i == REG_CONFIG && wb_sel_i[0])
      config_q <= wb_dat_i[4:0];
  end
endmodule : erma_core
`default_nettype wire

// ---- hdl/erma_pkg.sv ----
package erma_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CAUSE_W = 5;
  localparam int STAT_W = 4;
  localparam logic [31:0] RET_STEP = 32'h0000_0004;
  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int ST_PIE = 0;
  localparam int ST_U = 1;
  localparam int ST_EH = 2;
  localparam logic [STAT_W-1:0] STATUS_RST = 4'h0;
  // ---------------------------------------------------------------
  // Cause codes, lowest event bit position wins when several are present
  // ---------------------------------------------------------------
  localparam int NUM_EXC = 8;
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 5'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_IRQ = 5'h02;
  localparam logic [CAUSE_W-1:0] CAUSE_TRAP = 5'h03;
  localparam logic [CAUSE_W-1:0] CAUSE_UNIMP = 5'h04;
  localparam logic [CAUSE_W-1:0] CAUSE_ILLEGAL = 5'h05;
  localparam logic [CAUSE_W-1:0] CAUSE_MISDATA = 5'h06;
  localparam logic [CAUSE_W-1:0] CAUSE_MISDEST = 5'h07;
  localparam logic [CAUSE_W-1:0] CAUSE_DIVERR = 5'h08;
  localparam logic [CAUSE_W-1:0] CAUSE_MEMFAULT = 5'h09;
  // Event bit positions in the exception request vector
  localparam int EV_IRQ = 0;
  localparam int EV_MEMFAULT = 1;
  localparam int EV_MISDEST = 2;
  localparam int EV_UNIMP = 3;
  localparam int EV_ILLEGAL = 4;
  localparam int EV_TRAP = 5;
  localparam int EV_MISDATA = 6;
  localparam int EV_DIVERR = 7;
  // ---------------------------------------------------------------
  // Divide corner values
  // ---------------------------------------------------------------
  localparam logic [31:0] DIV_MIN_NEG = 32'h8000_0000;
  localparam logic [31:0] DIV_MINUS1 = 32'hFFFF_FFFF;
  localparam logic [31:0] DIV_ZERO = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Address map and cache indexing
  // ---------------------------------------------------------------
  localparam int BYPASS_BIT = 31;
  localparam int PAGE_BITS = 12;
  localparam int LINE_LO = 4;
  localparam int LINE_HI = 15;
  localparam int PFN_W = ADDR_W - PAGE_BITS;
  // Access size encoding
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // ---------------------------------------------------------------
  // Register map (word aligned byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ESTATUS = 8'h04;
  localparam logic [7:0] REG_RETADDR = 8'h08;
  localparam logic [7:0] REG_CAUSE = 8'h0C;
  localparam logic [7:0] REG_FAULT = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;
  // Config bits
  localparam int CF_EXTRA = 0;
  localparam int CF_MMU = 1;
  localparam int CF_MPU = 2;
  localparam int CF_CACHE = 3;
  localparam int CF_B31 = 4;
  localparam logic [4:0] CONFIG_RST = 5'h19;
  // Master state machine
  typedef enum logic [1:0] {
    ERMA_IDLE = 2'b00,
    ERMA_BUSY = 2'b01
  } erma_state_e;
endpackage : erma_pkg
